// ### inc/ectmr_pkg.sv
package ectmr_pkg;
  // Datapath sizes
  localparam int unsigned CNT_W_DEF = 16;
  localparam int unsigned DIV_W     = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CCR  = 8'h04;
  localparam logic [7:0] OFS_PRE  = 8'h08;
  localparam logic [7:0] OFS_OCTL = 8'h0C;
  localparam logic [7:0] OFS_CNT  = 8'h10;
  localparam logic [7:0] OFS_REGA = 8'h14;
  localparam logic [7:0] OFS_REGB = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  localparam logic [7:0] OFS_MASK = 8'h20;

  // Field positions
  localparam int unsigned MODE_OINV = 1;
  localparam int unsigned MODE_OPM  = 2;
  localparam int unsigned CCR_ACAP  = 0;
  localparam int unsigned CCR_REV   = 1;
  localparam int unsigned CCR_BCAP  = 2;
  localparam int unsigned PRE_CKS   = 0;
  localparam int unsigned PRE_ESA   = 3;
  localparam int unsigned PRE_ESB   = 5;
  localparam int unsigned OCTL_OEN  = 0;
  localparam int unsigned IRQ_A     = 0;
  localparam int unsigned IRQ_B     = 1;

  // Encodings
  localparam logic [1:0] OPM_EDGE_CLR = 2'b10;
  localparam logic [1:0] EDGE_FALL    = 2'b00;
  localparam logic [1:0] EDGE_RISE    = 2'b01;
  localparam logic [1:0] EDGE_BOTH    = 2'b11;
  localparam logic [1:0] CKS_DIV1     = 2'b00;
  localparam logic [1:0] CKS_DIV4     = 2'b01;
  localparam logic [1:0] CKS_DIV16    = 2'b10;

  // Reset values
  localparam logic [7:0]  REG_RST  = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
endpackage : ectmr_pkg

// ### inc/ectmr_edge_if.sv
`timescale 1ns/10ps
interface ectmr_edge_if;
  logic rise;
  logic fall;
  modport det (output rise, output fall);
  modport usr (input rise, input fall);
endinterface : ectmr_edge_if

// ### logic/ectmr_edge_det.sv
`timescale 1ns/10ps
module ectmr_edge_det
  import ectmr_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // Pin and edge events
  input  wire logic pin_i,
  ectmr_edge_if.det ev
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic smp;
    logic flt;
    logic rise;
    logic fall;
  } ectmr_det_st_t;

  ectmr_det_st_t st_ff;
  ectmr_det_st_t nxt_st;

  // Sync, two-sample filter, edge pulses
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = pin_i;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.smp   = st_ff.sync2;
    nxt_st.rise  = 1'b0;
    nxt_st.fall  = 1'b0;
    if (st_ff.sync2 == st_ff.smp && st_ff.sync2 != st_ff.flt) begin // [RULE18]
      nxt_st.flt  = st_ff.sync2;
      nxt_st.rise = st_ff.sync2;
      nxt_st.fall = ~st_ff.sync2;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ev.rise = st_ff.rise;
  assign ev.fall = st_ff.fall;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_rise_two_samples: assert property (st_ff.rise |-> $past(st_ff.sync2) && $past(st_ff.smp)) // [RULE18]
    else $error("rise without two high samples");
  a_fall_two_samples: assert property (st_ff.fall |-> !$past(st_ff.sync2) && !$past(st_ff.smp)) // [RULE18]
    else $error("fall without two low samples");
endmodule : ectmr_edge_det

// ### logic/ectmr_top.sv
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
// Behaviour
// [RULE1]: Output toggles on compare match; also on input A valid edge when selected.
// [RULE2]: Register B in capture mode loads count on input A edge; counter clears.
// [RULE3]: Each capture into register B raises interrupt B.
// [RULE4]: Register A compare match raises interrupt A; counter keeps running.
// [RULE5]: Register B compare match raises interrupt B; counter keeps running.
// [RULE6]: Reverse-phase select captures A on opposite input A edge, no interrupt A.
// [RULE7]: With reverse phase, input B valid edge raises interrupt A, no capture.
// [RULE8]: Software leaves the output pin unused when input B edges are used.
// [RULE9]: Register A capture trigger is input A reverse phase or input B edge.
// [RULE10]: Register B captures only from input A valid edges.
// [RULE11]: Counter readable by software at any time.
// [RULE12]: Rising valid plus reverse phase: clear on rise, capture A on fall.
// [RULE13]: Both edges valid on input A: each edge captures B and clears.
// [RULE14]: Both edges on input B capture into A without any clearing edge.
// [RULE15]: Software reads both capture registers right after interrupt B.
// [RULE16]: Mode bits 10 select edge clear-and-start; counter counts on count clock.
// [RULE17]: Without a clearing edge the counter wraps past maximum and continues.
// [RULE18]: Trigger edges are accepted only after two equal consecutive samples.
// [RULE19]: Software never selects the input A edge as count clock here.
module ectmr_top
  import ectmr_pkg::*;
#(
  parameter int unsigned CNT_W = CNT_W_DEF
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Trigger inputs and timer output
  input  wire logic        trigger_input_a_i,
  input  wire logic        trigger_input_b_i,
  output logic             timer_output_pin_o,
  // Interrupt
  output logic             irq_o
);
  typedef struct packed {
    logic [7:0]       mode;
    logic [7:0]       ccr;
    logic [7:0]       pre;
    logic [7:0]       octl;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] rega;
    logic [CNT_W-1:0] regb;
    logic [1:0]       stat;
    logic [1:0]       mask;
    logic             tout;
    logic [DIV_W-1:0] div;
    logic             wr_pend;
    logic [7:0]       wr_addr;
    logic [31:0]      rdata;
  } ectmr_top_st_t;

  ectmr_top_st_t st_ff;
  ectmr_top_st_t nxt_st;

  ectmr_edge_if ev_a ();
  ectmr_edge_if ev_b ();

  logic       active;
  logic       a_valid;
  logic       a_opp;
  logic       b_valid;
  logic       tick;
  logic       a_cap;
  logic       b_cap;
  logic       rev;
  logic       cmp_a;
  logic       cmp_b;
  logic       cap_b;
  logic       cap_a_rev;
  logic       cap_a_b;
  logic       b_irq_only;
  logic       edge_tog;
  logic       toggle;
  logic [1:0] set_irq;
  logic       acc;

  // Pick the edges that count for a given select
  function automatic logic ectmr_sel_edge(input logic [1:0] sel, input logic r, input logic f);
    logic hit;
    hit = 1'b0;
    case (sel)
      EDGE_RISE: hit = r;
      EDGE_FALL: hit = f;
      EDGE_BOTH: hit = r | f;
      default:   hit = 1'b0;
    endcase
    return hit;
  endfunction : ectmr_sel_edge

  // Edge detectors for both trigger inputs
  ectmr_edge_det u_det_a (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (trigger_input_a_i),
    .ev        (ev_a)
  );

  ectmr_edge_det u_det_b (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (trigger_input_b_i),
    .ev        (ev_b)
  );

  // Mode and valid-edge decode
  assign active  = st_ff.mode[MODE_OPM +: 2] == OPM_EDGE_CLR; // [RULE16]
  assign a_cap   = st_ff.ccr[CCR_ACAP];
  assign b_cap   = st_ff.ccr[CCR_BCAP];
  assign rev     = st_ff.ccr[CCR_REV];
  assign a_valid = ectmr_sel_edge(st_ff.pre[PRE_ESA +: 2], ev_a.rise, ev_a.fall);
  assign b_valid = ectmr_sel_edge(st_ff.pre[PRE_ESB +: 2], ev_b.rise, ev_b.fall);

  // Opposite phase of the input A valid edge
  always_comb begin
    case (st_ff.pre[PRE_ESA +: 2])
      EDGE_RISE: a_opp = ev_a.fall; // [RULE12]
      EDGE_FALL: a_opp = ev_a.rise;
      default:   a_opp = 1'b0;
    endcase
  end

  // Count clock enable from the prescaler
  always_comb begin
    case (st_ff.pre[PRE_CKS +: 2])
      CKS_DIV1:  tick = 1'b1;
      CKS_DIV4:  tick = &st_ff.div[1:0];
      CKS_DIV16: tick = &st_ff.div;
      default:   tick = a_valid;
    endcase
  end

  // Compare, capture and interrupt events
  assign cmp_a      = active & ~a_cap & tick & (st_ff.cnt == st_ff.rega); // [RULE4]
  assign cmp_b      = active & ~b_cap & tick & (st_ff.cnt == st_ff.regb); // [RULE5]
  assign cap_b      = active & b_cap & a_valid; // [RULE10]
  assign cap_a_rev  = active & a_cap & rev & a_opp; // [RULE9]
  assign cap_a_b    = active & a_cap & ~rev & b_valid; // [RULE14]
  assign b_irq_only = active & a_cap & rev & b_valid; // [RULE7]
  assign set_irq[IRQ_A] = cmp_a | cap_a_b | b_irq_only; // [RULE6]
  assign set_irq[IRQ_B] = cmp_b | cap_b; // [RULE3]
  assign edge_tog   = st_ff.mode[MODE_OINV] & active & a_valid;
  assign toggle     = st_ff.octl[OCTL_OEN] & (cmp_a | cmp_b | edge_tog); // [RULE1]
  assign acc        = hsel_i & hready_i & htrans_i[1];

  // Next state: bus first, then hardware events
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.div     = st_ff.div + 1'b1;
    nxt_st.wr_pend = acc & hwrite_i;
    nxt_st.wr_addr = acc ? haddr_i[7:0] : st_ff.wr_addr;
    // Read data sampled at the address phase
    if (acc && !hwrite_i) begin
      case (haddr_i[7:0])
        OFS_MODE: nxt_st.rdata = {24'h00_0000, st_ff.mode};
        OFS_CCR:  nxt_st.rdata = {24'h00_0000, st_ff.ccr};
        OFS_PRE:  nxt_st.rdata = {24'h00_0000, st_ff.pre};
        OFS_OCTL: nxt_st.rdata = {24'h00_0000, st_ff.octl};
        OFS_CNT:  nxt_st.rdata = 32'(st_ff.cnt); // [RULE11]
        OFS_REGA: nxt_st.rdata = 32'(st_ff.rega);
        OFS_REGB: nxt_st.rdata = 32'(st_ff.regb);
        OFS_STAT: nxt_st.rdata = 32'(st_ff.stat);
        OFS_MASK: nxt_st.rdata = 32'(st_ff.mask);
        default:  nxt_st.rdata = WORD_RST;
      endcase
    end
    // Write data phase
    if (st_ff.wr_pend) begin
      case (st_ff.wr_addr)
        OFS_MODE: nxt_st.mode = hwdata_i[7:0];
        OFS_CCR:  nxt_st.ccr  = hwdata_i[7:0];
        OFS_PRE:  nxt_st.pre  = hwdata_i[7:0];
        OFS_OCTL: nxt_st.octl = hwdata_i[7:0];
        OFS_REGA: nxt_st.rega = hwdata_i[CNT_W-1:0];
        OFS_REGB: nxt_st.regb = hwdata_i[CNT_W-1:0];
        OFS_STAT: nxt_st.stat = st_ff.stat & ~hwdata_i[1:0];
        OFS_MASK: nxt_st.mask = hwdata_i[1:0];
        default:  nxt_st.mask = st_ff.mask;
      endcase
    end
    // Counter: held at zero outside the mode, clear on valid edge, else count and wrap
    if (!active) begin
      nxt_st.cnt = '0;
    end else if (a_valid) begin
      nxt_st.cnt = '0; // [RULE2] [RULE13]
    end else if (tick) begin
      nxt_st.cnt = st_ff.cnt + 1'b1; // [RULE17]
    end
    // Captures win over a software write in the same cycle
    if (cap_b) begin
      nxt_st.regb = st_ff.cnt; // [RULE2]
    end
    if (cap_a_rev || cap_a_b) begin
      nxt_st.rega = st_ff.cnt; // [RULE9]
    end
    // Sticky status, set beats clear
    nxt_st.stat = nxt_st.stat | set_irq;
    if (toggle) begin
      nxt_st.tout = ~st_ff.tout; // [RULE1]
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_ff      <= '0;
      st_ff.mode <= REG_RST;
      st_ff.pre  <= REG_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign hrdata_o           = st_ff.rdata;
  assign hreadyout_o        = 1'b1;
  assign hresp_o            = 1'b0;
  assign timer_output_pin_o = st_ff.tout;
  assign irq_o              = |(st_ff.stat & st_ff.mask);

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_edge_clears_cnt: assert property (active && a_valid && $stable(st_ff.mode) |=> st_ff.cnt == '0) // [RULE2]
    else $error("valid edge did not clear counter");
  a_capture_into_b: assert property (cap_b |=> st_ff.regb == $past(st_ff.cnt)) // [RULE10]
    else $error("register B missed capture");
  a_capture_irq_b: assert property (cap_b |=> st_ff.stat[IRQ_B]) // [RULE3]
    else $error("capture B raised no interrupt");
  a_cmp_a_runs: assert property (cmp_a && !a_valid |=> st_ff.stat[IRQ_A] && st_ff.cnt == $past(st_ff.cnt) + 1'b1) // [RULE4]
    else $error("compare A wrong");
  a_cmp_b_runs: assert property (cmp_b && !a_valid |=> st_ff.stat[IRQ_B] && st_ff.cnt != '0 || $past(st_ff.cnt) == '1) // [RULE5]
    else $error("compare B wrong");
  a_rev_no_irq: assert property (cap_a_rev && !b_valid && !st_ff.stat[IRQ_A] && !(st_ff.wr_pend && st_ff.wr_addr == OFS_REGA)
                                 |=> st_ff.rega == $past(st_ff.cnt) && !st_ff.stat[IRQ_A]) // [RULE6]
    else $error("reverse capture wrong");
  a_b_edge_irq: assert property (b_irq_only && !cap_a_rev && !(st_ff.wr_pend && st_ff.wr_addr == OFS_REGA)
                                 |=> st_ff.stat[IRQ_A] && $stable(st_ff.rega)) // [RULE7]
    else $error("input B edge handling wrong");
  a_out_toggle: assert property (st_ff.octl[OCTL_OEN] && (cmp_a || edge_tog) |=> st_ff.tout != $past(st_ff.tout)) // [RULE1]
    else $error("output did not toggle");
  a_out_hold: assert property (!st_ff.octl[OCTL_OEN] |=> $stable(st_ff.tout)) // [RULE1]
    else $error("output toggled while disabled");
  a_cnt_wraps: assert property (active && tick && !a_valid && st_ff.cnt == '1 && $stable(st_ff.mode)
                                |=> st_ff.cnt == '0) // [RULE17]
    else $error("counter did not wrap");
  a_b_into_a: assert property (cap_a_b |=> st_ff.rega == $past(st_ff.cnt) && st_ff.stat[IRQ_A]) // [RULE14]
    else $error("input B capture into A wrong");

  c_clear_capture: cover property (cap_b ##[1:50] cap_b);
  c_pulse_measure: cover property (cap_a_rev ##[1:50] cap_b);
  c_wrap: cover property (active && tick && st_ff.cnt == '1);
  c_irq: cover property (irq_o ##1 !irq_o);
endmodule : ectmr_top

// ### tb/ectmr_pins_model.sv
`timescale 1ns/10ps
module ectmr_pins_model (
  // Clock
  input  wire logic ref_clk_i,
  // Trigger pins
  output logic      trig_a_o,
  output logic      trig_b_o,
  // Timer output, ignored while input B edges are in use
  input  wire logic tout_i
);
  // Both pins idle low
  initial begin
    trig_a_o = 1'b0;
    trig_b_o = 1'b0;
  end

  // Move one pin just after an edge, then hold it steady
  task automatic drive(input logic sel_b, input logic lvl, input int hold);
    @(posedge ref_clk_i);
    if (sel_b) trig_b_o <= lvl;
    else trig_a_o <= lvl;
    repeat (hold) @(posedge ref_clk_i); // Held well past the two-sample filter
  endtask : drive
endmodule : ectmr_pins_model

// ### tb/edge_clear_capture_timer_tb_top.sv
`timescale 1ns/10ps
module edge_clear_capture_timer_tb_top
  import ectmr_pkg::*;
;
  localparam int unsigned CW = 8;
  // Bench signals
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        ta;
  logic        tb_pin;
  logic        tout;
  logic        irq;
  logic        p;
  int          errors;
  int          n_compared;
  logic [31:0] rd_q;
  logic [31:0] v;

  // 125 MHz clock
  always #4 ref_clk_i = ~ref_clk_i;

  ectmr_top #(.CNT_W(CW)) i_ectmr_top (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .trigger_input_a_i(ta), .trigger_input_b_i(tb_pin),
    .timer_output_pin_o(tout), .irq_o(irq)
  );

  ectmr_pins_model i_ectmr_pins_model (
    .ref_clk_i(ref_clk_i), .trig_a_o(ta), .trig_b_o(tb_pin), .tout_i(tout)
  );

  // Counts and verdict
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // Bounded wait for hready at a rising edge
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      errors++;
      complete_run();
    end
  endtask : rdy

  // One single word transfer, address phase then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    rdy();
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    rdy();
    rd_q = hrdata;
  endtask : bus

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd_q, e);
  endtask : rdc

  // Main sequence
  initial begin
    hsel = 1'b0;
    haddr = WORD_RST;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = WORD_RST;
    errors = 0;
    n_compared = 0;
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    // Reset values, unmapped place, read-only counter
    rdc(OFS_MODE, WORD_RST);
    rdc(8'h24, WORD_RST);
    wr(OFS_REGA, 8'h5A);
    rdc(OFS_REGA, 32'h0000_005A);
    wr(OFS_CNT, 8'h33);
    rdc(OFS_CNT, WORD_RST);
    $display("test registers done");
    // Compare matches, interrupt mask and clear, wrap
    wr(OFS_REGB, 8'hC8);
    wr(OFS_REGA, 8'h05);
    wr(OFS_OCTL, 8'h01);
    wr(OFS_MASK, 8'h03);
    wr(OFS_MODE, 8'h08);
    repeat (20) @(posedge ref_clk_i);
    rdc(OFS_STAT, 32'h0000_0001);
    chk(32'(tout), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    bus(1'b0, OFS_CNT, 8'h00);
    chk(32'(rd_q > 32'h0000_0005), 32'h0000_0001);
    wr(OFS_MASK, 8'h02);
    @(negedge ref_clk_i); // Let the mask write settle before looking
    chk(32'(irq), WORD_RST);
    chk(32'(hresp), WORD_RST);
    wr(OFS_STAT, 8'h01);
    rdc(OFS_STAT, WORD_RST);
    repeat (300) @(posedge ref_clk_i);
    rdc(OFS_STAT, 32'h0000_0003);
    $display("test compare done");
    // Capture into B clears the counter
    wr(OFS_REGA, 8'hF0);
    wr(OFS_CCR, 8'h04);
    wr(OFS_PRE, 8'h08); // Count clock stays on the divider, never input A
    wr(OFS_MODE, 8'h00);
    wr(OFS_MODE, 8'h08);
    repeat (40) @(posedge ref_clk_i);
    wr(OFS_STAT, 8'h03);
    i_ectmr_pins_model.drive(1'b0, 1'b1, 8);
    bus(1'b0, OFS_CNT, 8'h00);
    v = rd_q;
    bus(1'b0, OFS_REGB, 8'h00);
    chk(32'(rd_q > v), 32'h0000_0001);
    rdc(OFS_STAT, 32'h0000_0002);
    $display("test capture done");
    // Pulse width with reverse-phase capture into A
    wr(OFS_CCR, 8'h07);
    wr(OFS_MODE, 8'h0A);
    wr(OFS_STAT, 8'h03);
    i_ectmr_pins_model.drive(1'b0, 1'b0, 10);
    p = tout;
    i_ectmr_pins_model.drive(1'b0, 1'b1, 15);
    chk(32'(tout ^ p), 32'h0000_0001);
    i_ectmr_pins_model.drive(1'b0, 1'b0, 12);
    i_ectmr_pins_model.drive(1'b0, 1'b1, 10);
    rdc(OFS_STAT, 32'h0000_0002);
    bus(1'b0, OFS_REGA, 8'h00);
    v = rd_q;
    bus(1'b0, OFS_REGB, 8'h00);
    chk(rd_q - v, 32'h0000_000D);
    $display("test pulse done");
    // Both edges valid on input A
    wr(OFS_CCR, 8'h04);
    wr(OFS_PRE, 8'h18);
    wr(OFS_STAT, 8'h03);
    p = tout;
    i_ectmr_pins_model.drive(1'b0, 1'b0, 10);
    chk(32'(tout ^ p), 32'h0000_0001);
    bus(1'b0, OFS_STAT, 8'h00);
    chk(32'(rd_q[1]), 32'h0000_0001);
    $display("test both edges done");
    // Input B edge with reverse phase: interrupt, no capture
    wr(OFS_REGB, 8'hF0);
    wr(OFS_CCR, 8'h03);
    wr(OFS_PRE, 8'h20);
    wr(OFS_REGA, 8'h55);
    wr(OFS_STAT, 8'h03);
    i_ectmr_pins_model.drive(1'b1, 1'b1, 10);
    bus(1'b0, OFS_STAT, 8'h00);
    chk(32'(rd_q[0]), 32'h0000_0001);
    rdc(OFS_REGA, 32'h0000_0055);
    // Both edges on input B capture into A
    wr(OFS_CCR, 8'h01);
    wr(OFS_PRE, 8'h70);
    wr(OFS_STAT, 8'h03);
    i_ectmr_pins_model.drive(1'b1, 1'b0, 10);
    bus(1'b0, OFS_REGA, 8'h00);
    chk(32'(rd_q !== 32'h0000_0055), 32'h0000_0001);
    bus(1'b0, OFS_STAT, 8'h00);
    chk(32'(rd_q[0]), 32'h0000_0001);
    $display("test input b done");
    // Divide by 16: about one tick per 16 clocks
    wr(OFS_MODE, 8'h00);
    wr(OFS_PRE, 8'h02);
    wr(OFS_MODE, 8'h08);
    repeat (100) @(posedge ref_clk_i);
    bus(1'b0, OFS_CNT, 8'h00);
    chk(32'(rd_q >= 32'h0000_0005 && rd_q <= 32'h0000_0008), 32'h0000_0001);
    $display("test divider done");
    complete_run();
  end
endmodule : edge_clear_capture_timer_tb_top
